// ==== include/itfm_pkg.sv ====
// Constants, register map and carrier types of the input terminal function map
`default_nettype none
package itfm_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int           NUM_TERM      = 5;
   localparam int           NUM_POL       = 6;
   localparam int           NUM_FUNCS     = 33;
   localparam int           NUM_FUNCS_EXT = 34;
   localparam int           ADDR_W        = 8;
   localparam int           CODE_W        = 8;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0]   FUNC_BASE     = 8'h00;
   localparam logic [7:0]   POL_BASE      = 8'h14;
   localparam logic [7:0]   STAT_ADDR     = 8'h2c;
   localparam logic [7:0]   MASK_ADDR     = 8'h30;
   localparam logic [7:0]   CMD_ADDR      = 8'h34;
   localparam logic [7:0]   DRIVE_ADDR    = 8'h38;
   // ----------------------------------------
   // Option codes
   // ----------------------------------------
   localparam logic [7:0]   CODE_RV       = 8'h01;
   localparam logic [7:0]   CODE_CF_LSB   = 8'h02;
   localparam logic [7:0]   CODE_JOG      = 8'h06;
   localparam logic [7:0]   CODE_DCB      = 8'h07;
   localparam logic [7:0]   CODE_MOTOR2   = 8'h08;
   localparam logic [7:0]   CODE_RAMP2    = 8'h09;
   localparam logic [7:0]   CODE_COAST    = 8'h0b;
   localparam logic [7:0]   CODE_TRIP     = 8'h0c;
   localparam logic [7:0]   CODE_GUARD    = 8'h0d;
   localparam logic [7:0]   CODE_ANALOG   = 8'h10;
   localparam logic [7:0]   CODE_CLEAR    = 8'h12;
   localparam logic [63:0]  VALID_CODES   = 64'h0000_0000_19f5_fbfe;
   localparam logic [7:0]   POL_NO        = 8'h00;
   localparam logic [7:0]   POL_NC        = 8'h01;
   localparam logic [7:0]   TRIP_CODE_EXT = 8'h0c;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0]   FUNC1_RST     = 8'h12;
   localparam logic [7:0]   FUNC2_RST     = 8'h10;
   localparam logic [7:0]   FUNC3_RST     = 8'h03;
   localparam logic [7:0]   FUNC3_RST_US  = 8'h0d;
   localparam logic [7:0]   FUNC4_RST     = 8'h02;
   localparam logic [7:0]   FUNC5_RST     = 8'h01;
   localparam logic [7:0]   POL3_RST_US   = 8'h01;
   // ----------------------------------------
   // Status bits
   // ----------------------------------------
   localparam int           ST_TRIP       = 0;
   localparam int           ST_CLEAR      = 1;
   localparam int           ST_REFUSE     = 2;
   localparam int           ST_W          = 3;

   typedef struct packed {
      logic       external_trip_input;
      logic       trip_clear_input;
      logic       unattended_start_guard;
      logic       analog_source_select;
      logic       coast_stop_cmd;
      logic       two_stage_ramp_select;
      logic       second_motor_select;
      logic       dc_injection_brake_cmd;
      logic       jog_cmd;
      logic [3:0] speed_index;
      logic       forward_run_cmd;
      logic       reverse_run_cmd;
   } itfm_cmd_type;

   typedef struct packed {
      logic       resume_blocked;
      logic       trip_latched;
      logic       power_up_reset;
      logic       motor_output_on;
      logic       reverse_dir;
      logic       run_mode;
   } itfm_drive_type;
endpackage
`default_nettype wire

// ==== logic/itfm_top.sv ====
// Input terminal function map with APB register access
//
// Contract
// - Each terminal takes any function independently
// - Inputs are binary, active means one
// - One function-select register per terminal
// - Distinct default roles after reset
// - Polarity 00 normal, 01 inverts input
// - Six polarity registers including forward input
// - Normally closed refused on reset function
// - Reverse input active runs reverse; the code runs forward when forward is also active
// - Four speed bits form binary index
// - Jog input runs at jog frequency
// - Brake input enables DC braking
// - Second motor set while input active
// - Second-stage ramps while input active
// - Coast input switches motor output off
// - Trip input rising edge latches E12
// - Clear input clears trip, output off
// - Guard at power-up blocks run resume
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module itfm_top #(
   parameter bit          US_VARIANT  = 1'b0,
   parameter logic [63:0] CODE_SET    = itfm_pkg::VALID_CODES
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst_b,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [itfm_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic                             pready,
   output logic                             pslverr,
   output logic [31:0]                      prdata,
   // Terminal inputs
   input  wire logic [itfm_pkg::NUM_TERM-1:0] term_in,
   input  wire logic                        forward_run_input,
   // Drive commands
   output itfm_pkg::itfm_cmd_type           cmd,
   output itfm_pkg::itfm_drive_type         drive,
   output logic [7:0]                       trip_code,
   output logic                             irq
);
   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [7:0]                func_sel [itfm_pkg::NUM_TERM];
   logic [7:0]                polarity [itfm_pkg::NUM_POL];
   logic [itfm_pkg::ST_W-1:0] status;
   logic [itfm_pkg::ST_W-1:0] mask;
   logic                      setup_ph;
   logic                      access_ph;
   logic                      wr_done;
   logic                      rd_done;
   logic                      addr_ok;
   logic                      wr_ok;
   logic [7:0]                wbyte;
   logic [7:0]                next_rdata;
   logic [2:0]                t_idx;
   logic [2:0]                p_idx;
   logic                      is_func;
   logic                      is_pol;

   function automatic logic [7:0] func_rst(input int t);
      case (t)
         0:       func_rst = itfm_pkg::FUNC1_RST;
         1:       func_rst = itfm_pkg::FUNC2_RST;
         2:       func_rst = US_VARIANT ? itfm_pkg::FUNC3_RST_US : itfm_pkg::FUNC3_RST;
         3:       func_rst = itfm_pkg::FUNC4_RST;
         default: func_rst = itfm_pkg::FUNC5_RST;
      endcase
   endfunction

   function automatic logic [7:0] pol_rst(input int p);
      pol_rst = (US_VARIANT && p == 2) ? itfm_pkg::POL3_RST_US : itfm_pkg::POL_NO;
   endfunction

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign pready    = 1'b1;
   assign wbyte     = pwdata[7:0];
   assign wr_done   = access_ph && pwrite && addr_ok && wr_ok;
   assign rd_done   = access_ph && !pwrite && addr_ok;
   assign t_idx     = 3'(paddr[7:2]);
   assign p_idx     = 3'((paddr - itfm_pkg::POL_BASE) >> 2);

   always_comb begin
      is_func = 1'b0;
      is_pol  = 1'b0;
      addr_ok = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         addr_ok = 1'b0;
      end else if (paddr < itfm_pkg::POL_BASE) begin
         is_func = 1'b1;
         addr_ok = 1'b1;
      end else if (paddr < itfm_pkg::STAT_ADDR) begin
         is_pol  = 1'b1;
         addr_ok = 1'b1;
      end else if (paddr == itfm_pkg::STAT_ADDR || paddr == itfm_pkg::MASK_ADDR) begin
         addr_ok = 1'b1;
      end else if (paddr == itfm_pkg::CMD_ADDR || paddr == itfm_pkg::DRIVE_ADDR) begin
         addr_ok = !pwrite;
      end
   end

   // Refused writes answer with an error and leave the register alone
   always_comb begin
      wr_ok = 1'b1;
      if (is_func) begin
         wr_ok = CODE_SET[wbyte[5:0]] && (wbyte[7:6] == 2'b00);
         if (wbyte == itfm_pkg::CODE_CLEAR && polarity[t_idx] == itfm_pkg::POL_NC) begin
            wr_ok = 1'b0;
         end
      end else if (is_pol) begin
         wr_ok = (wbyte == itfm_pkg::POL_NO) || (wbyte == itfm_pkg::POL_NC);
         if (p_idx < 3'(itfm_pkg::NUM_TERM) && wbyte == itfm_pkg::POL_NC
             && func_sel[p_idx] == itfm_pkg::CODE_CLEAR) begin
            wr_ok = 1'b0;
         end
      end
   end

   assign pslverr = access_ph && !(addr_ok && (wr_ok || !pwrite));

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      for (int t = 0; t < itfm_pkg::NUM_TERM; t++) begin
         if (!rst_b) begin
            func_sel[t] <= func_rst(t);
         end else if (wr_done && is_func && t_idx == 3'(t)) begin
            func_sel[t] <= wbyte;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      for (int p = 0; p < itfm_pkg::NUM_POL; p++) begin
         if (!rst_b) begin
            polarity[p] <= pol_rst(p);
         end else if (wr_done && is_pol && p_idx == 3'(p)) begin
            polarity[p] <= wbyte;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         mask <= '0;
      end else if (wr_done && paddr == itfm_pkg::MASK_ADDR) begin
         mask <= pwdata[itfm_pkg::ST_W-1:0];
      end
   end

   // ----------------------------------------
   // Polarity and function decode
   // ----------------------------------------
   logic [itfm_pkg::NUM_TERM-1:0] eff;
   logic                          fwd_eff;
   logic [63:0]                   hit [itfm_pkg::NUM_TERM];
   logic [63:0]                   act;

   genvar g;
   generate
      for (g = 0; g < itfm_pkg::NUM_TERM; g++) begin : g_term
         assign eff[g] = term_in[g] ^ polarity[g][0];
         assign hit[g] = eff[g] ? (64'h1 << func_sel[g][5:0]) : 64'h0;
      end
   endgenerate

   assign fwd_eff = forward_run_input ^ polarity[itfm_pkg::NUM_POL-1][0];

   always_comb begin
      act = 64'h0;
      for (int t = 0; t < itfm_pkg::NUM_TERM; t++) begin
         act = act | hit[t];
      end
   end

   itfm_pkg::itfm_cmd_type next_cmd;

   always_comb begin
      next_cmd                        = '0;
      next_cmd.reverse_run_cmd        = act[itfm_pkg::CODE_RV[5:0]];
      next_cmd.forward_run_cmd        = fwd_eff;
      next_cmd.speed_index            = act[itfm_pkg::CODE_CF_LSB[5:0] +: 4];
      next_cmd.jog_cmd                = act[itfm_pkg::CODE_JOG[5:0]];
      next_cmd.dc_injection_brake_cmd = act[itfm_pkg::CODE_DCB[5:0]];
      next_cmd.second_motor_select    = act[itfm_pkg::CODE_MOTOR2[5:0]];
      next_cmd.two_stage_ramp_select  = act[itfm_pkg::CODE_RAMP2[5:0]];
      next_cmd.coast_stop_cmd         = act[itfm_pkg::CODE_COAST[5:0]];
      next_cmd.analog_source_select   = act[itfm_pkg::CODE_ANALOG[5:0]];
      next_cmd.unattended_start_guard = act[itfm_pkg::CODE_GUARD[5:0]];
      next_cmd.trip_clear_input       = act[itfm_pkg::CODE_CLEAR[5:0]];
      next_cmd.external_trip_input    = act[itfm_pkg::CODE_TRIP[5:0]];
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cmd <= '0;
      end else begin
         cmd <= next_cmd;
      end
   end

   // ----------------------------------------
   // Trip, clear and power-up guard
   // ----------------------------------------
   logic trip_rise;
   logic powerup_done;
   logic run_req;
   logic next_run;
   logic trip_latched;
   logic resume_blocked;
   logic run_mode;
   logic reverse_dir;
   logic motor_output_on;
   logic power_up_reset;

   // Edge taken on the registered copy, so a slow contact gives one event
   assign trip_rise = next_cmd.external_trip_input && !cmd.external_trip_input;
   assign run_req   = cmd.forward_run_cmd || cmd.reverse_run_cmd || cmd.jog_cmd;

   // A new trip edge wins over a clear held in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         trip_latched <= 1'b0;
         trip_code    <= 8'h00;
      end else if (trip_rise) begin
         trip_latched <= 1'b1;
         trip_code    <= itfm_pkg::TRIP_CODE_EXT;
      end else if (cmd.trip_clear_input) begin
         trip_latched <= 1'b0;
         trip_code    <= 8'h00;
      end
   end

   // Guard sampled once, on the first edge after reset release
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         powerup_done   <= 1'b0;
         resume_blocked <= 1'b0;
      end else if (!powerup_done) begin
         powerup_done   <= 1'b1;
         resume_blocked <= next_cmd.unattended_start_guard;
      end else if (!run_req) begin
         resume_blocked <= 1'b0;
      end
   end

   assign next_run = run_req && !trip_latched && !cmd.trip_clear_input
                     && !resume_blocked && powerup_done;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         run_mode        <= 1'b0;
         reverse_dir     <= 1'b0;
         motor_output_on <= 1'b0;
         power_up_reset  <= 1'b0;
      end else begin
         run_mode        <= next_run;
         reverse_dir     <= cmd.reverse_run_cmd && !cmd.forward_run_cmd;
         motor_output_on <= next_run && !cmd.coast_stop_cmd;
         power_up_reset  <= cmd.trip_clear_input;
      end
   end

   // Fields gathered here so each flop keeps a single driving process
   assign drive = itfm_pkg::itfm_drive_type'{
      resume_blocked:  resume_blocked,
      trip_latched:    trip_latched,
      power_up_reset:  power_up_reset,
      motor_output_on: motor_output_on,
      reverse_dir:     reverse_dir,
      run_mode:        run_mode
   };

   // ----------------------------------------
   // Event status and interrupt
   // ----------------------------------------
   logic [itfm_pkg::ST_W-1:0] ev;
   logic                      stat_rd;

   assign ev[itfm_pkg::ST_TRIP]   = trip_rise;
   assign ev[itfm_pkg::ST_CLEAR]  = next_cmd.trip_clear_input && !cmd.trip_clear_input;
   assign ev[itfm_pkg::ST_REFUSE] = access_ph && pwrite && addr_ok && !wr_ok;
   assign stat_rd                 = rd_done && paddr == itfm_pkg::STAT_ADDR;

   // Set wins over the read that clears
   // Only bits already returned are cleared, so a setup-cycle event survives
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         status <= '0;
      end else if (stat_rd) begin
         status <= (status & ~prdata[itfm_pkg::ST_W-1:0]) | ev;
      end else begin
         status <= status | ev;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end

   // ----------------------------------------
   // Read data, loaded in the setup cycle
   // ----------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      if (is_func) begin
         next_rdata = func_sel[t_idx];
      end else if (is_pol) begin
         next_rdata = polarity[p_idx];
      end else if (paddr == itfm_pkg::STAT_ADDR) begin
         next_rdata = 8'(status);
      end else if (paddr == itfm_pkg::MASK_ADDR) begin
         next_rdata = 8'(mask);
      end else if (paddr == itfm_pkg::DRIVE_ADDR) begin
         next_rdata = 8'(drive);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         if (addr_ok && paddr == itfm_pkg::CMD_ADDR) begin
            prdata <= 32'(cmd);
         end else begin
            prdata <= addr_ok ? 32'(next_rdata) : 32'h0000_0000;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/input_terminal_function_map_bench.sv ====
// Self-checking bench for the input terminal function map
`timescale 1ns/1ps
`default_nettype none
module input_terminal_function_map_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic                     ref_clk = 1'b0;
   logic                     rst_b, psel, penable, pwrite, pready, pslverr, irq, fwd;
   logic [7:0]               paddr, trip_code;
   logic [31:0]              pwdata, prdata;
   logic [4:0]               term_in;
   logic [5:0]               contact, nc;
   itfm_pkg::itfm_cmd_type   cmd;
   itfm_pkg::itfm_drive_type drive;
   int                       errors, checks_done;
   localparam logic [7:0] RST_VAL [11] = '{8'h12, 8'h10, 8'h03, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h00, 8'h00};
   localparam logic [7:0] CODES [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                                         8'h0b, 8'h10, 8'h0d, 8'h12, 8'h0c};
   localparam int         BITS [14] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14};

   always #25 ref_clk = ~ref_clk;

   itfm_switches u_itfm_switches (.ref_clk(ref_clk), .contact_closed(contact), .wired_nc(nc), .term_in(term_in),
      .forward_run_input(fwd));
   itfm_top u_itfm_top (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .term_in(term_in),
      .forward_run_input(fwd), .cmd(cmd), .drive(drive), .trip_code(trip_code), .irq(irq));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         errors++;
         $display("unexpected value at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Holds the request until pready is seen high; idle edge after so strobes never toggle twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
      logic [31:0] r;
      logic        er;
      apb(1'b1, a, {24'h0, d}, r, er);
      check({31'h0, er}, {31'h0, e});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic e);
      logic [31:0] r;
      logic        er;
      apb(1'b0, a, 32'h0, r, er);
      check({31'h0, er}, {31'h0, e});
      if (!e) check(r, want);
   endtask
   // Switch model, command stage and drive stage each add one edge
   task automatic settle();
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic press(input logic [5:0] c);
      contact <= c;
      settle();
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {rst_b, psel, penable, pwrite} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      contact = 6'h00;
      nc = 6'h00;
      errors = 0;
      checks_done = 0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 11; i++) rd(8'(4 * i), {24'h0, RST_VAL[i]}, 1'b0);
      rd(8'h3c, 32'h0, 1'b1);
      wr(8'h34, 8'h00, 1'b1);
      wr(8'h00, 8'h0a, 1'b1);
      wr(8'h00, 8'h40, 1'b1);
      rd(8'h00, 32'h12, 1'b0);
      wr(8'h14, 8'h01, 1'b1);
      wr(8'h14, 8'h02, 1'b1);
      rd(8'h2c, 32'h4, 1'b0);
      foreach (CODES[i]) begin
         wr(8'h04, CODES[i], 1'b0);
         press(6'h02);
         check(32'(cmd), 32'h1 << BITS[i]);
         press(6'h00);
         check(32'(cmd), 32'h0);
      end
      check({drive.trip_latched, trip_code}, 9'h10c);
      check(32'(irq), 32'h0);
      wr(8'h30, 8'h01, 1'b0);
      settle();
      check(32'(irq), 32'h1);
      rd(8'h2c, 32'h3, 1'b0);
      settle();
      check(32'(irq), 32'h0);
      wr(8'h30, 8'h00, 1'b0);
      press(6'h02);
      check(32'(irq), 32'h0);
      rd(8'h2c, 32'h1, 1'b0);
      press(6'h01);
      check({drive.trip_latched, drive.power_up_reset, trip_code}, 10'h100);
      press(6'h00);
      wr(8'h04, 8'h05, 1'b0);
      wr(8'h10, 8'h04, 1'b0);
      press(6'h1e);
      check(32'(cmd.speed_index), 32'hf);
      press(6'h0a);
      check(32'(cmd.speed_index), 32'h9);
      wr(8'h18, 8'h01, 1'b0);
      nc <= 6'h02;
      press(6'h00);
      check(32'(cmd.speed_index), 32'h0);
      press(6'h02);
      check(32'(cmd.speed_index), 32'h8);
      wr(8'h04, 8'h12, 1'b1);
      nc <= 6'h00;
      wr(8'h18, 8'h00, 1'b0);
      wr(8'h10, 8'h01, 1'b0);
      press(6'h10);
      check(32'(drive), 32'h07);
      wr(8'h04, 8'h0b, 1'b0);
      press(6'h12);
      check(32'(drive), 32'h03);
      wr(8'h04, 8'h06, 1'b0);
      press(6'h02);
      check(32'(drive), 32'h05);
      press(6'h00);
      check(32'(drive), 32'h00);
      // Forward held through a second reset resumes, no guard assigned
      press(6'h20);
      check(32'(drive), 32'h05);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      settle();
      check(32'(drive), 32'h05);
      rd(8'h08, 32'h03, 1'b0);
      stop_test();
   end
   initial begin
      #(50 * 20000);
      errors++;
      stop_test();
   end
endmodule
`default_nettype wire

// ==== test/itfm_switches.sv ====
// Model of the contacts wired to the terminal inputs
`timescale 1ns/1ps
`default_nettype none
module itfm_switches (
   // Clock
   input  wire logic       ref_clk,
   // Operated contacts, bit 5 is the forward contact
   input  wire logic [5:0] contact_closed,
   // Contacts that open when operated
   input  wire logic [5:0] wired_nc,
   // Terminal lines
   output logic [4:0]      term_in,
   output logic            forward_run_input
);
   // Lines settle one clock late, like a slow relay, never in the edge's own step
   always_ff @(posedge ref_clk) begin
      term_in           <= contact_closed[4:0] ^ wired_nc[4:0];
      forward_run_input <= contact_closed[5] ^ wired_nc[5];
   end
endmodule
`default_nettype wire

// ==== test/itfm_top_props.sv ====
// Port checker for the input terminal function map
`timescale 1ns/1ps
`default_nettype none
module itfm_top_props (
   // Clock and reset
   input wire logic                     ref_clk,
   input wire logic                     rst_b,
   // Bus
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pslverr,
   // Commands and drive state
   input wire itfm_pkg::itfm_cmd_type   cmd,
   input wire itfm_pkg::itfm_drive_type drive,
   input wire logic [7:0]               trip_code
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   // Guarded by the past reset so a short reset cannot leak stale commands
   property p_rev;
      $past(rst_b) |-> drive.reverse_dir == $past(cmd.reverse_run_cmd && !cmd.forward_run_cmd);
   endproperty
   a_rev: assert property (p_rev) else $error("reverse direction mismatch");
   property p_run;
      drive.run_mode && $past(rst_b) |-> $past(cmd.forward_run_cmd || cmd.reverse_run_cmd || cmd.jog_cmd);
   endproperty
   a_run: assert property (p_run) else $error("run without request");
   property p_coast;
      drive.motor_output_on |-> drive.run_mode && !$past(cmd.coast_stop_cmd);
   endproperty
   a_coast: assert property (p_coast) else $error("output on while coasting");
   property p_trip;
      $rose(cmd.external_trip_input) |-> drive.trip_latched && trip_code == 8'h0c;
   endproperty
   a_trip: assert property (p_trip) else $error("trip edge not latched");
   property p_code;
      trip_code == (drive.trip_latched ? 8'h0c : 8'h00);
   endproperty
   a_code: assert property (p_code) else $error("trip code mismatch");
   property p_hold;
      drive.trip_latched |=> drive.trip_latched || cmd.trip_clear_input || $past(cmd.trip_clear_input);
   endproperty
   a_hold: assert property (p_hold) else $error("trip lost without clear");
   property p_clear;
      cmd.trip_clear_input |=> drive.power_up_reset && !drive.motor_output_on;
   endproperty
   a_clear: assert property (p_clear) else $error("clear input not honoured");
   property p_guard;
      drive.resume_blocked |-> !drive.run_mode;
   endproperty
   a_guard: assert property (p_guard) else $error("run while resume blocked");
   property p_err;
      pslverr |-> psel && penable;
   endproperty
   a_err: assert property (p_err) else $error("error outside access phase");
   c_trip: cover property (drive.trip_latched);
   c_motor: cover property (drive.motor_output_on && drive.reverse_dir);
   c_err: cover property (pslverr);
endmodule
bind itfm_top itfm_top_props u_itfm_top_props (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pslverr(pslverr), .cmd(cmd), .drive(drive), .trip_code(trip_code));
`default_nettype wire
